// file: verilog/mbac_pkg.sv
// package for the mode based access checker: modes, regions, groups, carriers
package mbac_pkg;

	typedef enum logic [2:0] {
		MODE_BOOT,
		MODE_TEST,
		MODE_FIRMWARE,
		MODE_SYSTEM,
		MODE_USER
	} mbac_mode_e;

	// memory regions as decoded by the address map in front of the checker
	typedef enum logic [3:0] {
		RGN_NONE,
		RGN_TEST_ROM,
		RGN_FW_ROM,
		RGN_APP_ROM,
		RGN_FW_EEPROM,
		RGN_APP_EEPROM,
		RGN_SEC_ROWS,
		RGN_FW_RAM,
		RGN_APP_RAM,
		RGN_PK_RAM
	} mbac_region_e;

	// special function register groups
	typedef enum logic [2:0] {
		GRP_SEG_CFG,
		GRP_SYS_MGMT,
		GRP_FW_CFG,
		GRP_FW_OS,
		GRP_TEST,
		GRP_HW_COMP,
		GRP_CORE_GEN,
		GRP_CORE_BANKED
	} mbac_group_e;

	// individual registers that carry their own exceptions
	typedef enum logic [2:0] {
		SPC_NONE,
		SPC_CORE_CTRL_STATUS,
		SPC_CLOCK_SELECT,
		SPC_RELOCATION_POINTER_TWO,
		SPC_RANDOM_OUTPUT,
		SPC_CIPHER_KEY
	} mbac_special_e;

	typedef enum logic [1:0] {
		SRC_CORE,
		SRC_COPY,
		SRC_PKC
	} mbac_source_e;

	localparam int MBAC_ADDR_W = 24;
	localparam int MBAC_FW_W = 16;
	localparam int MBAC_HW_W = 16;
	localparam int MBAC_HALF_W = 12;
	localparam int MBAC_PTR_W = 16;
	localparam logic [MBAC_PTR_W-1:0] MBAC_PTR_RESET = 16'h0000;
	localparam logic [3:0] MBAC_HW_IDX_W = 4'h4;

	// read, write, fetch permission triple
	typedef struct packed {
		logic rd;
		logic wr;
		logic fx;
	} mbac_perm_s;

	// one memory request from the core or a master
	typedef struct packed {
		logic valid;
		mbac_source_e src;
		mbac_region_e region;
		logic [MBAC_ADDR_W-1:0] addr;
		logic rd;
		logic wr;
		logic fx;
		logic code_in_eeprom;
		mbac_perm_s seg_perm;
	} mbac_mem_req_s;

	// one register request from the core
	typedef struct packed {
		logic valid;
		mbac_group_e group;
		mbac_special_e special;
		logic [3:0] hw_index;
		logic rd;
		logic wr;
		logic [MBAC_HW_W-1:0] seg_hw_perm;
	} mbac_reg_req_s;

	// outcome for one request
	typedef struct packed {
		logic grant;
		logic deny;
	} mbac_result_s;

endpackage

// file: verilog/mbac_checker.sv
// mode based access checker for memory and register requests
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps

module mbac_checker
	import mbac_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire mbac_pkg::mbac_mode_e cpu_mode,
	input wire logic fw_called_from_system,
	input wire logic copy_start,
	input wire mbac_pkg::mbac_mem_req_s mem_req,
	input wire mbac_pkg::mbac_reg_req_s reg_req,
	input wire logic [7:0] cfg_addr,
	input wire logic [15:0] cfg_wdata,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	output logic [15:0] cfg_rdata,
	output mbac_pkg::mbac_result_s mem_res,
	output mbac_pkg::mbac_result_s reg_res,
	output logic access_exception
);
	import mbac_pkg::*;

	localparam logic [7:0] CFG_XBASE_LO = 8'h00;
	localparam logic [7:0] CFG_XBASE_HI = 8'h01;
	localparam logic [7:0] CFG_XSIZE_LO = 8'h02;
	localparam logic [7:0] CFG_XSIZE_HI = 8'h03;
	localparam logic [7:0] CFG_FW_LO = 8'h04;
	localparam logic [7:0] CFG_FW_HI = 8'h05;
	localparam logic [7:0] CFG_OPTIONS = 8'h06;
	localparam logic [7:0] CFG_SEG_PTR = 8'h07;
	localparam logic [7:0] CFG_STATUS = 8'h08;
	localparam int OPT_EE_CODE_NO_ROM = 0;
	localparam int OPT_COPY_NO_ROM = 1;
	localparam int OPT_COPY_NO_EE = 2;
	localparam int FW_EE_RD = 0;
	localparam int FW_EE_WR = 1;
	localparam int FW_EE_FX = 2;
	localparam logic [15:0] ZERO16 = 16'h0000;

	logic [MBAC_HALF_W-1:0] xbase_lo_q;
	logic [MBAC_HALF_W-1:0] xbase_hi_q;
	logic [MBAC_HALF_W-1:0] xsize_lo_q;
	logic [MBAC_HALF_W-1:0] xsize_hi_q;
	logic [MBAC_FW_W-1:0] fw_ctrl_lo_q;
	logic [MBAC_FW_W-1:0] fw_ctrl_hi_q;
	logic [2:0] options_q;
	logic [MBAC_PTR_W-1:0] seg_ptr_q;
	mbac_mode_e copy_mode_q;
	logic [15:0] deny_count_q;

	// config register writes; pointer restrictive at reset
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			xbase_lo_q <= '0;
			xbase_hi_q <= '0;
			xsize_lo_q <= '0;
			xsize_hi_q <= '0;
			fw_ctrl_lo_q <= '0;
			fw_ctrl_hi_q <= '0;
			options_q <= '0;
			seg_ptr_q <= MBAC_PTR_RESET;
		end else if (cfg_wr) begin
			case (cfg_addr)
				CFG_XBASE_LO: xbase_lo_q <= cfg_wdata[MBAC_HALF_W-1:0];
				CFG_XBASE_HI: xbase_hi_q <= cfg_wdata[MBAC_HALF_W-1:0];
				CFG_XSIZE_LO: xsize_lo_q <= cfg_wdata[MBAC_HALF_W-1:0];
				CFG_XSIZE_HI: xsize_hi_q <= cfg_wdata[MBAC_HALF_W-1:0];
				CFG_FW_LO: fw_ctrl_lo_q <= cfg_wdata;
				CFG_FW_HI: fw_ctrl_hi_q <= cfg_wdata;
				CFG_OPTIONS: options_q <= cfg_wdata[2:0];
				CFG_SEG_PTR: seg_ptr_q <= cfg_wdata;
				default: ;
			endcase
		end
	end

	// read data stands one cycle after the strobe and only then
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			cfg_rdata <= ZERO16;
		end else if (cfg_rd) begin
			case (cfg_addr)
				CFG_XBASE_LO: cfg_rdata <= {4'h0, xbase_lo_q};
				CFG_XBASE_HI: cfg_rdata <= {4'h0, xbase_hi_q};
				CFG_XSIZE_LO: cfg_rdata <= {4'h0, xsize_lo_q};
				CFG_XSIZE_HI: cfg_rdata <= {4'h0, xsize_hi_q};
				CFG_FW_LO: cfg_rdata <= fw_ctrl_lo_q;
				CFG_FW_HI: cfg_rdata <= fw_ctrl_hi_q;
				CFG_OPTIONS: cfg_rdata <= {13'h0000, options_q};
				CFG_SEG_PTR: cfg_rdata <= seg_ptr_q;
				CFG_STATUS: cfg_rdata <= deny_count_q;
				default: cfg_rdata <= ZERO16;
			endcase
		end else begin
			cfg_rdata <= ZERO16;
		end
	end

	// copy engine keeps its start mode so a mode change mid-copy has no effect
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			copy_mode_q <= MODE_BOOT;
		end else if (copy_start) begin
			copy_mode_q <= cpu_mode;
		end
	end

	// exchange window: base and size each split in two 12-bit halves
	logic [2*MBAC_HALF_W-1:0] xbase;
	logic [2*MBAC_HALF_W:0] xend;
	logic in_xwin;
	assign xbase = {xbase_hi_q, xbase_lo_q};
	assign xend = {1'b0, xbase} + {1'b0, xsize_hi_q, xsize_lo_q};
	assign in_xwin = ({1'b0, mem_req.addr} >= {1'b0, xbase}) &&
		({1'b0, mem_req.addr} < xend);

	// permission triple builder, used for every region decision except user app eeprom, which takes seg_perm as is
	function automatic mbac_perm_s perm(input logic r, input logic w, input logic x);
		perm.rd = r;
		perm.wr = w;
		perm.fx = x;
	endfunction

	// test whether the request's operations all fall inside a permission
	function automatic logic fits(input mbac_perm_s p, input logic r, input logic w,
		input logic x);
		fits = (!r || p.rd) && (!w || p.wr) && (!x || p.fx);
	endfunction

	mbac_mode_e eff_mode;
	mbac_perm_s mem_perm;
	mbac_perm_s fw_ee_perm;
	logic mem_block;

	assign eff_mode = (mem_req.src == SRC_COPY) ? copy_mode_q : cpu_mode;
	assign fw_ee_perm = perm(fw_ctrl_lo_q[FW_EE_RD], fw_ctrl_lo_q[FW_EE_WR],
		fw_ctrl_lo_q[FW_EE_FX]);

	// memory permission by mode and region
	always_comb begin
		mem_perm = perm(1'b0, 1'b0, 1'b0);
		if (mem_req.src == SRC_PKC) begin
			if (mem_req.region == RGN_PK_RAM) mem_perm = perm(1'b1, 1'b1, 1'b0);
		end else begin
			case (eff_mode)
				MODE_BOOT: begin
					case (mem_req.region)
						RGN_TEST_ROM: mem_perm = perm(1'b1, 1'b0, 1'b1);
						RGN_FW_EEPROM: mem_perm = perm(1'b1, 1'b1, 1'b1);
						RGN_FW_RAM: mem_perm = perm(1'b1, 1'b1, 1'b0);
						RGN_SEC_ROWS: mem_perm = perm(1'b1, 1'b0, 1'b0);
						default: ;
					endcase
				end
				MODE_TEST: begin
					case (mem_req.region)
						RGN_TEST_ROM, RGN_FW_ROM, RGN_APP_ROM:
							mem_perm = perm(1'b1, 1'b0, 1'b1);
						RGN_FW_EEPROM, RGN_APP_EEPROM, RGN_SEC_ROWS:
							mem_perm = perm(1'b1, 1'b1, 1'b1);
						RGN_FW_RAM, RGN_APP_RAM, RGN_PK_RAM:
							mem_perm = perm(1'b1, 1'b1, 1'b0);
						default: ;
					endcase
				end
				MODE_FIRMWARE: begin
					case (mem_req.region)
						RGN_FW_ROM: mem_perm = perm(1'b1, 1'b0, 1'b1);
						RGN_FW_RAM: mem_perm = perm(1'b1, 1'b1, 1'b0);
						// integrity handling reads and writes both eeprom regions; fetch from fw eeprom only with fw_ctrl_lo_q bit FW_EE_FX set
						RGN_FW_EEPROM: mem_perm = perm(1'b1, 1'b1, fw_ee_perm.fx);
						RGN_APP_EEPROM: mem_perm = perm(1'b1, 1'b1, 1'b0);
						RGN_SEC_ROWS: mem_perm = perm(1'b1, 1'b0, 1'b0);
						RGN_APP_RAM: if (in_xwin) mem_perm = perm(1'b1, 1'b1, 1'b0);
						default: ;
					endcase
				end
				MODE_SYSTEM: begin
					case (mem_req.region)
						RGN_APP_ROM: mem_perm = perm(1'b1, 1'b0, 1'b1);
						RGN_APP_EEPROM: mem_perm = perm(1'b1, 1'b1, 1'b1);
						RGN_APP_RAM: mem_perm = perm(1'b1, 1'b1, 1'b0);
						default: ;
					endcase
				end
				MODE_USER: begin
					case (mem_req.region)
						RGN_APP_ROM: mem_perm = perm(mem_req.seg_perm.rd, 1'b0,
							mem_req.seg_perm.fx);
						RGN_APP_EEPROM: mem_perm = mem_req.seg_perm;
						RGN_APP_RAM: mem_perm = perm(mem_req.seg_perm.rd,
							mem_req.seg_perm.wr, 1'b0);
						default: ;
					endcase
				end
				default: ;
			endcase
		end
	end

	// optional read blocks on rom and eeprom
	logic is_rom;
	logic is_ee;
	assign is_rom = (mem_req.region == RGN_TEST_ROM) || (mem_req.region == RGN_FW_ROM) ||
		(mem_req.region == RGN_APP_ROM);
	assign is_ee = (mem_req.region == RGN_FW_EEPROM) || (mem_req.region == RGN_APP_EEPROM) ||
		(mem_req.region == RGN_SEC_ROWS);
	assign mem_block = mem_req.rd && (
		(options_q[OPT_EE_CODE_NO_ROM] && mem_req.src == SRC_CORE &&
			mem_req.code_in_eeprom && is_rom) ||
		(options_q[OPT_COPY_NO_ROM] && mem_req.src == SRC_COPY && is_rom) ||
		(options_q[OPT_COPY_NO_EE] && mem_req.src == SRC_COPY && is_ee));

	logic mem_ok;
	assign mem_ok = fits(mem_perm, mem_req.rd, mem_req.wr, mem_req.fx) && !mem_block;

	// register permission: group per mode, then per-register exceptions
	logic reg_rd_ok;
	logic reg_wr_ok;
	logic hw_fw_bit;
	logic hw_seg_bit;
	assign hw_fw_bit = fw_ctrl_hi_q[reg_req.hw_index];
	assign hw_seg_bit = reg_req.seg_hw_perm[reg_req.hw_index];

	always_comb begin
		reg_rd_ok = 1'b0;
		reg_wr_ok = 1'b0;
		case (reg_req.group)
			GRP_CORE_GEN: begin
				reg_rd_ok = 1'b1;
				reg_wr_ok = 1'b1;
			end
			GRP_CORE_BANKED: begin
				reg_rd_ok = (cpu_mode == MODE_SYSTEM) || (cpu_mode == MODE_USER);
				reg_wr_ok = reg_rd_ok;
			end
			GRP_SEG_CFG: begin
				reg_rd_ok = (cpu_mode == MODE_SYSTEM);
				reg_wr_ok = reg_rd_ok;
			end
			GRP_TEST: begin
				reg_rd_ok = (cpu_mode == MODE_TEST);
				reg_wr_ok = reg_rd_ok;
			end
			GRP_FW_CFG: begin
				reg_rd_ok = (cpu_mode != MODE_USER);
				reg_wr_ok = (cpu_mode == MODE_BOOT) || (cpu_mode == MODE_TEST) ||
					(cpu_mode == MODE_SYSTEM);
			end
			GRP_FW_OS: begin
				reg_rd_ok = (cpu_mode == MODE_BOOT) || (cpu_mode == MODE_TEST) ||
					(cpu_mode == MODE_FIRMWARE);
				reg_wr_ok = reg_rd_ok;
			end
			GRP_SYS_MGMT: begin
				reg_rd_ok = (cpu_mode != MODE_FIRMWARE) && (cpu_mode != MODE_USER);
				reg_wr_ok = reg_rd_ok;
			end
			GRP_HW_COMP: begin
				case (cpu_mode)
					MODE_FIRMWARE: reg_rd_ok = hw_fw_bit;
					MODE_USER: reg_rd_ok = hw_seg_bit;
					default: reg_rd_ok = 1'b1;
				endcase
				reg_wr_ok = reg_rd_ok;
			end
			default: ;
		endcase
		// per-register exceptions applied last
		case (reg_req.special)
			SPC_CORE_CTRL_STATUS:
				if (cpu_mode == MODE_FIRMWARE || cpu_mode == MODE_USER)
					reg_rd_ok = 1'b1;
			SPC_CLOCK_SELECT:
				if (cpu_mode == MODE_FIRMWARE) reg_rd_ok = 1'b1;
			SPC_RELOCATION_POINTER_TWO: reg_rd_ok = 1'b0;
			SPC_CIPHER_KEY: reg_rd_ok = 1'b0;
			SPC_RANDOM_OUTPUT: reg_wr_ok = 1'b0;
			default: ;
		endcase
	end

	logic reg_ok;
	assign reg_ok = (!reg_req.rd || reg_rd_ok) && (!reg_req.wr || reg_wr_ok);

	// registered verdicts; a denied access never gets a grant
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			mem_res <= '0;
			reg_res <= '0;
			access_exception <= 1'b0;
		end else begin
			mem_res.grant <= mem_req.valid && mem_ok;
			mem_res.deny <= mem_req.valid && !mem_ok;
			reg_res.grant <= reg_req.valid && reg_ok;
			reg_res.deny <= reg_req.valid && !reg_ok;
			access_exception <= (mem_req.valid && !mem_ok) ||
				(reg_req.valid && !reg_ok);
		end
	end

	// saturating count of cycles with a denial (a memory and a register denial in one cycle count once), readable as block status
	always_ff @(posedge core_clk) begin
		if (!reset_n) begin
			deny_count_q <= ZERO16;
		end else if (((mem_req.valid && !mem_ok) || (reg_req.valid && !reg_ok)) &&
			(deny_count_q != 16'hFFFF)) begin
			deny_count_q <= deny_count_q + 16'h0001;
		end
	end

	// assertions
	a_seg_ptr_reset: assert property (@(posedge core_clk)
		!reset_n |=> seg_ptr_q == MBAC_PTR_RESET) else $error("pointer not cleared");
	a_reg_deny_exc: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_req.valid && !reg_ok |=> access_exception && reg_res.deny)
		else $error("register denial without exception");
	a_mem_deny_exc: assert property (@(posedge core_clk) disable iff (!reset_n)
		mem_req.valid && !mem_ok |=> access_exception && !mem_res.grant)
		else $error("memory denial not suppressed");
	a_seg_cfg_sys: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_req.valid && (reg_req.rd || reg_req.wr) && reg_req.group == GRP_SEG_CFG &&
		cpu_mode != MODE_SYSTEM
		|=> reg_res.deny) else $error("segment config reached outside system");
	a_key_unread: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_req.valid && reg_req.rd && (reg_req.special == SPC_CIPHER_KEY ||
		reg_req.special == SPC_RELOCATION_POINTER_TWO) |=> !reg_res.grant)
		else $error("unreadable register read");
	a_user_rom_wr: assert property (@(posedge core_clk) disable iff (!reset_n)
		mem_req.valid && cpu_mode == MODE_USER && mem_req.src == SRC_CORE &&
		mem_req.wr && mem_req.region == RGN_APP_ROM |=> mem_res.deny)
		else $error("user rom write granted");
	// a start strobe followed by a quiet cycle
	sequence s_copy_launch;
		copy_start ##1 !copy_start;
	endsequence
	a_copy_mode_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
		s_copy_launch |-> copy_mode_q == $past(cpu_mode))
		else $error("copy mode not held");
	a_copy_mode_keep: assert property (@(posedge core_clk) disable iff (!reset_n)
		!copy_start |=> copy_mode_q == $past(copy_mode_q))
		else $error("copy mode moved without a start");
	a_banked_deny: assert property (@(posedge core_clk) disable iff (!reset_n)
		reg_req.valid && (reg_req.rd || reg_req.wr) && reg_req.group == GRP_CORE_BANKED &&
		(cpu_mode == MODE_BOOT || cpu_mode == MODE_TEST || cpu_mode == MODE_FIRMWARE)
		|=> reg_res.deny) else $error("banked core register granted");
	a_sys_app_ram: assert property (@(posedge core_clk) disable iff (!reset_n)
		mem_req.valid && mem_req.src == SRC_CORE && cpu_mode == MODE_SYSTEM &&
		mem_req.region == RGN_APP_RAM && !mem_req.fx |=> mem_res.grant)
		else $error("system ram access denied");
	// firmware entered from system keeps eeprom integrity access
	a_fw_call_ee: assert property (@(posedge core_clk) disable iff (!reset_n)
		mem_req.valid && mem_req.src == SRC_CORE && cpu_mode == MODE_FIRMWARE &&
		fw_called_from_system && mem_req.region == RGN_APP_EEPROM && !mem_req.fx
		|=> mem_res.grant) else $error("called firmware denied eeprom");

endmodule // mbac_checker

// file: tb/mbac_core_model.sv
// processor core model issuing memory and register requests to the checker
`timescale 1ns/10ps

module mbac_core_model
	import mbac_pkg::*;
(
	input wire logic core_clk,
	output mbac_pkg::mbac_mem_req_s mem_req,
	output mbac_pkg::mbac_reg_req_s reg_req,
	input wire mbac_pkg::mbac_result_s mem_res,
	input wire mbac_pkg::mbac_result_s reg_res,
	input wire logic access_exception
);
	// idle bus at time zero
	initial begin
		mem_req = '0;
		reg_req = '0;
	end

	// one memory request held for one edge; fields flip on release so stale values never pass
	task automatic mem_op(input mbac_source_e s, input mbac_region_e r, input logic [2:0] op,
		input logic [2:0] p, input logic cie, input logic [23:0] a, output logic [2:0] res);
		@(posedge core_clk);
		mem_req <= '{1'b1, s, r, a, op[2], op[1], op[0], cie, p};
		@(posedge core_clk);
		mem_req <= {1'b0, ~mem_req[$bits(mem_req)-2:0]};
		@(posedge core_clk);
		res = {mem_res.grant, mem_res.deny, access_exception};
	endtask

	// one register request, same timing as the memory side
	task automatic reg_op(input mbac_group_e g, input mbac_special_e sp, input logic [3:0] i,
		input logic [1:0] rw, input logic [15:0] hp, output logic [2:0] res);
		@(posedge core_clk);
		reg_req <= '{1'b1, g, sp, i, rw[1], rw[0], hp};
		@(posedge core_clk);
		reg_req <= {1'b0, ~reg_req[$bits(reg_req)-2:0]};
		@(posedge core_clk);
		res = {reg_res.grant, reg_res.deny, access_exception};
	endtask
endmodule // mbac_core_model

// file: tb/tb_top.sv
// self-checking bench for the mode based access checker
`timescale 1ns/10ps

module tb_top;
	import mbac_pkg::*;
	localparam logic [2:0] RD = 3'h4;
	localparam logic [2:0] WR = 3'h2;
	localparam logic [2:0] FX = 3'h1;
	localparam logic [2:0] OK = 3'h4;
	localparam logic [2:0] NO = 3'h3;
	localparam logic [1:0] R = 2'h2;
	localparam logic [1:0] W = 2'h1;
	logic core_clk, reset_n, fw_called_from_system, copy_start, cfg_wr, cfg_rd, access_exception;
	logic eeprom_code;
	mbac_mode_e cpu_mode;
	mbac_source_e src;
	mbac_mem_req_s mem_req;
	mbac_reg_req_s reg_req;
	mbac_result_s mem_res, reg_res;
	logic [7:0] cfg_addr;
	logic [15:0] cfg_wdata, cfg_rdata;
	logic [23:0] adr;
	int miscompares = 0;
	int n_compared = 0;
	int n_denied = 0;

	mbac_checker u_dut (.core_clk(core_clk), .reset_n(reset_n), .cpu_mode(cpu_mode),
		.fw_called_from_system(fw_called_from_system), .copy_start(copy_start),
		.mem_req(mem_req), .reg_req(reg_req), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .mem_res(mem_res),
		.reg_res(reg_res), .access_exception(access_exception));

	mbac_core_model u_core (.core_clk(core_clk), .mem_req(mem_req), .reg_req(reg_req),
		.mem_res(mem_res), .reg_res(reg_res), .access_exception(access_exception));

	// 100 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// grant means grant only; deny means deny plus exception
	task automatic mem(input mbac_region_e r, input logic [2:0] op, input logic [2:0] p,
		input logic [2:0] exp);
		logic [2:0] res;
		u_core.mem_op(src, r, op, p, eeprom_code, adr, res);
		cmp({13'h0, res}, {13'h0, exp});
		if (exp == NO) n_denied++;
	endtask

	task automatic rg(input mbac_group_e g, input mbac_special_e sp, input logic [3:0] i,
		input logic [1:0] rw, input logic [15:0] hp, input logic [2:0] exp);
		logic [2:0] res;
		u_core.reg_op(g, sp, i, rw, hp, res);
		cmp({13'h0, res}, {13'h0, exp});
		if (exp == NO) n_denied++;
	endtask

	task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic cfg_read(input logic [7:0] a, input logic [15:0] exp);
		@(posedge core_clk);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge core_clk);
		cfg_rd <= 1'b0;
		@(posedge core_clk);
		cmp(cfg_rdata, exp);
	endtask

	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		miscompares++;
		give_verdict();
	end

	initial begin
		reset_n = 1'b0;
		cpu_mode = MODE_BOOT;
		fw_called_from_system = 1'b0;
		copy_start = 1'b0;
		cfg_addr = 8'h00;
		cfg_wdata = 16'h0000;
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		eeprom_code = 1'b0;
		src = SRC_CORE;
		adr = 24'h000000;
		repeat (2) @(posedge core_clk);
		reset_n <= 1'b1;
		// reset values, then an unmapped place
		for (int k = 0; k < 9; k++) begin
			cfg_read(8'(k), 16'h0000);
		end
		cfg_read(8'h20, 16'h0000);
		mem(RGN_TEST_ROM, RD, 3'h0, OK);
		mem(RGN_TEST_ROM, WR, 3'h0, NO);
		mem(RGN_FW_EEPROM, FX, 3'h0, OK);
		mem(RGN_FW_RAM, WR, 3'h0, OK);
		mem(RGN_FW_RAM, FX, 3'h0, NO);
		mem(RGN_APP_RAM, RD, 3'h0, NO);
		mem(RGN_SEC_ROWS, RD, 3'h0, OK);
		rg(GRP_TEST, SPC_NONE, 4'h0, R, 16'h0000, NO);
		rg(GRP_SEG_CFG, SPC_NONE, 4'h0, W, 16'h0000, NO);
		rg(GRP_CORE_BANKED, SPC_NONE, 4'h0, R, 16'h0000, NO);
		rg(GRP_HW_COMP, SPC_NONE, 4'h1, W, 16'h0000, OK);
		cpu_mode <= MODE_TEST;
		mem(RGN_APP_ROM, FX, 3'h0, OK);
		mem(RGN_APP_EEPROM, WR, 3'h0, OK);
		mem(RGN_APP_RAM, WR, 3'h0, OK);
		mem(RGN_APP_RAM, FX, 3'h0, NO);
		rg(GRP_TEST, SPC_NONE, 4'h0, W, 16'h0000, OK);
		rg(GRP_SEG_CFG, SPC_NONE, 4'h0, R, 16'h0000, NO);
		rg(GRP_CORE_BANKED, SPC_NONE, 4'h0, W, 16'h0000, NO);
		cpu_mode <= MODE_FIRMWARE;
		mem(RGN_FW_ROM, FX, 3'h0, OK);
		mem(RGN_FW_RAM, RD, 3'h0, OK);
		mem(RGN_TEST_ROM, RD, 3'h0, NO);
		mem(RGN_APP_EEPROM, WR, 3'h0, OK);
		mem(RGN_SEC_ROWS, RD, 3'h0, OK);
		mem(RGN_FW_EEPROM, FX, 3'h0, NO);
		cfg_write(8'h04, 16'h0004);
		cfg_read(8'h04, 16'h0004);
		mem(RGN_FW_EEPROM, FX, 3'h0, OK);
		fw_called_from_system <= 1'b1;
		mem(RGN_APP_EEPROM, RD, 3'h0, OK);
		// exchange window 0x100 .. 0x10F, both edges probed
		cfg_write(8'h00, 16'h0100);
		cfg_write(8'h02, 16'h0010);
		adr = 24'h000100;
		mem(RGN_APP_RAM, WR, 3'h0, OK);
		adr = 24'h000110;
		mem(RGN_APP_RAM, RD, 3'h0, NO);
		adr = 24'h0000FF;
		mem(RGN_APP_RAM, RD, 3'h0, NO);
		rg(GRP_FW_CFG, SPC_NONE, 4'h0, R, 16'h0000, OK);
		rg(GRP_FW_CFG, SPC_NONE, 4'h0, W, 16'h0000, NO);
		rg(GRP_FW_OS, SPC_NONE, 4'h0, W, 16'h0000, OK);
		rg(GRP_HW_COMP, SPC_NONE, 4'h3, W, 16'hFFFF, NO);
		cfg_write(8'h05, 16'h0008);
		rg(GRP_HW_COMP, SPC_NONE, 4'h3, W, 16'h0000, OK);
		rg(GRP_HW_COMP, SPC_CLOCK_SELECT, 4'h0, R, 16'h0000, OK);
		rg(GRP_SYS_MGMT, SPC_CORE_CTRL_STATUS, 4'h0, R, 16'h0000, OK);
		rg(GRP_SYS_MGMT, SPC_CORE_CTRL_STATUS, 4'h0, W, 16'h0000, NO);
		rg(GRP_CORE_BANKED, SPC_NONE, 4'h0, R, 16'h0000, NO);
		cpu_mode <= MODE_SYSTEM;
		mem(RGN_APP_ROM, FX, 3'h0, OK);
		mem(RGN_APP_ROM, WR, 3'h0, NO);
		mem(RGN_APP_EEPROM, WR, 3'h0, OK);
		mem(RGN_APP_RAM, WR, 3'h0, OK);
		mem(RGN_FW_RAM, RD, 3'h0, NO);
		rg(GRP_SEG_CFG, SPC_NONE, 4'h0, W, 16'h0000, OK);
		rg(GRP_SYS_MGMT, SPC_NONE, 4'h0, W, 16'h0000, OK);
		rg(GRP_FW_CFG, SPC_NONE, 4'h0, W, 16'h0000, OK);
		rg(GRP_HW_COMP, SPC_NONE, 4'h5, W, 16'h0000, OK);
		rg(GRP_SYS_MGMT, SPC_RELOCATION_POINTER_TWO, 4'h0, R, 16'h0000, NO);
		rg(GRP_HW_COMP, SPC_CIPHER_KEY, 4'h0, R, 16'h0000, NO);
		rg(GRP_HW_COMP, SPC_RANDOM_OUTPUT, 4'h0, R, 16'h0000, OK);
		rg(GRP_HW_COMP, SPC_RANDOM_OUTPUT, 4'h0, W, 16'h0000, NO);
		// copy engine keeps the mode it started in
		@(posedge core_clk);
		copy_start <= 1'b1;
		@(posedge core_clk);
		copy_start <= 1'b0;
		cpu_mode <= MODE_USER;
		src = SRC_COPY;
		mem(RGN_APP_ROM, RD, 3'h0, OK);
		src = SRC_CORE;
		mem(RGN_APP_ROM, RD, 3'h4, OK);
		mem(RGN_APP_ROM, RD, 3'h0, NO);
		mem(RGN_APP_ROM, WR, 3'h7, NO);
		mem(RGN_APP_RAM, FX, 3'h7, NO);
		mem(RGN_APP_EEPROM, WR, 3'h2, OK);
		rg(GRP_HW_COMP, SPC_NONE, 4'h2, W, 16'h0004, OK);
		rg(GRP_HW_COMP, SPC_NONE, 4'h2, W, 16'hFFFB, NO);
		rg(GRP_SYS_MGMT, SPC_CORE_CTRL_STATUS, 4'h0, R, 16'h0000, OK);
		rg(GRP_CORE_BANKED, SPC_NONE, 4'h0, W, 16'h0000, OK);
		rg(GRP_SEG_CFG, SPC_NONE, 4'h0, W, 16'hFFFF, NO);
		for (int k = 0; k < 5; k++) begin
			cpu_mode <= mbac_mode_e'(k);
			rg(GRP_CORE_GEN, SPC_NONE, 4'h0, W, 16'h0000, OK);
		end
		// optional read blocks: the eeprom-code block alone, then both copy blocks together
		cpu_mode <= MODE_SYSTEM;
		cfg_write(8'h06, 16'h0001);
		eeprom_code = 1'b1;
		mem(RGN_APP_ROM, RD, 3'h0, NO);
		eeprom_code = 1'b0;
		mem(RGN_APP_ROM, RD, 3'h0, OK);
		cfg_write(8'h06, 16'h0006);
		src = SRC_COPY;
		mem(RGN_APP_ROM, RD, 3'h0, NO);
		mem(RGN_APP_EEPROM, RD, 3'h0, NO);
		src = SRC_PKC;
		mem(RGN_PK_RAM, WR, 3'h0, OK);
		mem(RGN_APP_RAM, RD, 3'h0, NO);
		// pointer and window halves read back; upper bits of a half are not kept
		cfg_write(8'h07, 16'h5A3C);
		cfg_read(8'h07, 16'h5A3C);
		cfg_write(8'h03, 16'hF123);
		cfg_read(8'h03, 16'h0123);
		// every expected denial counted once in the status word
		cfg_read(8'h08, 16'(n_denied));
		give_verdict();
	end
endmodule // tb_top
